// ---- common/ext_bus_regs.svh ----
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ADDRESS_UPDATE_CONTROL_IDX  24'hfee01e
`define SELECT_OUTPUT_CONTROL_IDX   24'hfee01f
`define SELECT_PORT_DIRECTION_IDX   24'hfee020
`define BUS_STATUS_IDX              24'hfee021

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ADDRESS_UPDATE_SELECT_BIT   0
`define ADDRESS_UPDATE_RESET        8'hff
`define ADDRESS_UPDATE_FIXED_ONES   7'h7f
`define SELECT_OUTPUT_RESET         4'h0
`define PORT_DIR_RESET_ROM_OFF      4'h1
`define PORT_DIR_RESET_ROM_ON       4'h0

// ----------------------------------------------------------------------------
// Address map constants
// ----------------------------------------------------------------------------
`define AREA2_START_16M             24'h400000
`define AREA2_START_1M              24'h040000
`define AREA_MSB_16M                23
`define AREA_MSB_1M                 19
`define BEAT_STEP_8BIT              24'h000001
`define BEAT_STEP_16BIT             24'h000002

`endif

// ---- common/ext_bus_pkg.sv ----
package ext_bus_pkg;

    // Bus cycle sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_T1   = 4'h2,
        ST_T2   = 4'h4,
        ST_T3   = 4'h8
    } bus_state_t;

    // Transfer size requested by an internal master
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } xfer_size_t;

endpackage

// ---- rtl/area_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_regs.svh"

// Classifies a bus address into one of eight areas and flags on-chip space
module area_decode
    import ext_bus_pkg::*;
#(
    parameter logic [23:0] ROM_BYTES = 24'h020000,
    parameter logic [23:0] RAM_BYTES = 24'h004000,
    parameter logic [23:0] REG_BYTES = 24'h012000
)
(
    input  wire logic [23:0] addr_i,
    input  wire logic        mode_16m_i,
    input  wire logic        rom_enable_i,
    input  wire logic        ram_enable_i,
    output logic      [2:0]  area_o,
    output logic             internal_o
);

    logic [23:0] top_dist;

    // ------------------------------------------------------------------------
    // Area number from the top three address bits of the mode's space
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (mode_16m_i)
        begin
            area_o   = addr_i[`AREA_MSB_16M -: 3];
            top_dist = ~addr_i;
        end
        else
        begin
            area_o   = addr_i[`AREA_MSB_1M -: 3];
            top_dist = {4'h0, ~addr_i[19:0]};
        end
    end

    // ------------------------------------------------------------------------
    // On-chip ROM sits at the bottom, registers and RAM at the top
    // ------------------------------------------------------------------------
    always_comb
    begin
        internal_o = 1'b0;
        if (rom_enable_i && (addr_i < ROM_BYTES))
        begin
            internal_o = 1'b1;
        end
        if (top_dist < REG_BYTES)
        begin
            internal_o = 1'b1;
        end
        if (ram_enable_i && (top_dist < (REG_BYTES + RAM_BYTES)))
        begin
            internal_o = 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/external_bus_select_align.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_regs.svh"

module external_bus_select_align
    import ext_bus_pkg::*;
#(
    parameter logic [23:0] ROM_BYTES = 24'h020000,
    parameter logic [23:0] RAM_BYTES = 24'h004000,
    parameter logic [23:0] REG_BYTES = 24'h012000
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Mode straps
    input  wire logic        expanded_i,
    input  wire logic        mode_16m_i,
    input  wire logic        rom_enable_i,
    input  wire logic        ram_enable_i,
    input  wire logic [7:0]  area_width_config_i,
    // Wishbone slave
    input  wire logic [25:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Internal master request
    input  wire logic        req_valid_i,
    input  wire logic [23:0] req_addr_i,
    input  wire logic        req_we_i,
    input  wire logic [1:0]  req_size_i,
    input  wire logic [31:0] req_wdata_i,
    output logic             req_ready_o,
    output logic             done_o,
    output logic      [31:0] rdata_o,
    // Refresh requests
    input  wire logic        refresh_i,
    input  wire logic        refresh_self_i,
    // External pins
    output logic      [23:0] addr_o,
    output logic      [7:0]  cs_n_o,
    output logic      [7:0]  cs_oe_n_o,
    output logic             rd_n_o,
    output logic             upper_write_strobe_n_o,
    output logic             lower_write_strobe_n_o,
    output logic      [7:0]  data_hi_o,
    output logic      [7:0]  data_lo_o,
    output logic             data_hi_oe_n_o,
    output logic             data_lo_oe_n_o,
    input  wire logic [7:0]  data_hi_i,
    input  wire logic [7:0]  data_lo_i
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (ROM_BYTES == 24'h000000)
    begin : g_rom_check
        $error("ROM_BYTES must be nonzero");
    end
    if (REG_BYTES == 24'h000000)
    begin : g_reg_check
        $error("REG_BYTES must be nonzero");
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    bus_state_t  state;
    logic        update_select;
    logic [3:0]  select_output_control;
    logic [3:0]  port_direction;
    logic        wb_hit;
    logic [23:0] wb_index;
    logic [2:0]  req_area;
    logic        req_internal;
    logic [23:0] cur_addr;
    logic [2:0]  cur_area;
    logic        cur_we;
    logic        cur_wide;
    xfer_size_t  cur_size;
    logic [2:0]  beats_left;
    logic [31:0] wshift;
    logic [31:0] rshift;
    logic        last_internal;
    logic        word_beat;
    logic        req_wide;
    logic [2:0]  next_beats;
    logic [31:0] next_wshift;
    logic [7:0]  select_enable;
    logic        wb_write;

    localparam logic [7:0] UPDATE_RESET = `ADDRESS_UPDATE_RESET;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    area_decode #(
        .ROM_BYTES (ROM_BYTES),
        .RAM_BYTES (RAM_BYTES),
        .REG_BYTES (REG_BYTES)
    ) u_decode (
        .addr_i       (req_addr_i),
        .mode_16m_i   (mode_16m_i),
        .rom_enable_i (rom_enable_i),
        .ram_enable_i (ram_enable_i),
        .area_o       (req_area),
        .internal_o   (req_internal)
    );

    // ------------------------------------------------------------------------
    // Wishbone register port
    // ------------------------------------------------------------------------

    // Register hit, one access per request handshake
    assign wb_index = adr_i[25:2];
    assign wb_hit   = cyc_i && stb_i && !ack_o;

    // Writes land only at the edge where the master samples ack high
    assign wb_write = cyc_i && stb_i && ack_o && we_i && sel_i[0];

    // Acknowledge one cycle after the request, unmapped addresses included
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= wb_hit;
    end

    // Address update mode bit; reset selects mode 1
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            update_select <= UPDATE_RESET[`ADDRESS_UPDATE_SELECT_BIT];
        else if (wb_write && (wb_index == `ADDRESS_UPDATE_CONTROL_IDX))
            update_select <= dat_i[`ADDRESS_UPDATE_SELECT_BIT];
    end

    // Pin enables for selects 4 to 7; inputs until software sets them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            select_output_control <= `SELECT_OUTPUT_RESET;
        else if (wb_write && (wb_index == `SELECT_OUTPUT_CONTROL_IDX))
            select_output_control <= dat_i[3:0];
    end

    // Direction bits for selects 0 to 3; reset value follows the ROM strap
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            port_direction <= rom_enable_i ? `PORT_DIR_RESET_ROM_ON
                                           : `PORT_DIR_RESET_ROM_OFF;
        else if (wb_write && (wb_index == `SELECT_PORT_DIRECTION_IDX))
            port_direction <= dat_i[3:0];
    end

    // Read data; unmapped indexes return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h00000000;
        end
        else if (wb_hit && !we_i)
        begin
            unique case (wb_index)
                `ADDRESS_UPDATE_CONTROL_IDX:
                    dat_o <= {24'h000000, `ADDRESS_UPDATE_FIXED_ONES, update_select};
                `SELECT_OUTPUT_CONTROL_IDX:
                    dat_o <= {28'h0000000, select_output_control};
                `SELECT_PORT_DIRECTION_IDX:
                    dat_o <= {28'h0000000, port_direction};
                `BUS_STATUS_IDX:
                    dat_o <= {24'h000000, cur_area, last_internal, state};
                default:
                    dat_o <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Transfer planning
    // ------------------------------------------------------------------------

    // Beat count and left-aligned write data for a new request
    always_comb
    begin
        req_wide    = !area_width_config_i[req_area];
        next_beats  = 3'h1;
        next_wshift = req_wdata_i;
        unique case (req_size_i)
            SIZE_WORD:
            begin
                next_beats  = req_wide ? 3'h1 : 3'h2;
                next_wshift = {req_wdata_i[15:0], 16'h0000};
            end
            SIZE_LONG:
            begin
                next_beats  = req_wide ? 3'h2 : 3'h4;
                next_wshift = req_wdata_i;
            end
            default:
            begin
                next_beats  = 3'h1;
                next_wshift = {req_wdata_i[7:0], 24'h000000};
            end
        endcase
    end

    // A wide beat moves a word unless it is a single byte
    assign word_beat = cur_wide && (cur_size != SIZE_BYTE);

    // Which area selects may reach their pins
    assign select_enable = {select_output_control, port_direction};

    // ------------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------------

    // State flow: each beat runs T1, T2, T3
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (req_valid_i && req_ready_o && !req_internal)
                        state <= ST_T1;
                ST_T1:
                    state <= ST_T2;
                ST_T2:
                    state <= ST_T3;
                ST_T3:
                    state <= (beats_left == 3'h1) ? ST_IDLE : ST_T1;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Transfer context latched on acceptance, advanced after each beat
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur_addr      <= 24'h000000;
            cur_area      <= 3'h0;
            cur_we        <= 1'b0;
            cur_wide      <= 1'b0;
            cur_size      <= SIZE_BYTE;
            beats_left    <= 3'h0;
            wshift        <= 32'h00000000;
            last_internal <= 1'b0;
        end
        else if (state == ST_IDLE && req_valid_i && req_ready_o)
        begin
            cur_addr      <= req_addr_i;
            cur_area      <= req_area;
            cur_we        <= req_we_i;
            cur_wide      <= req_wide;
            cur_size      <= xfer_size_t'(req_size_i == 2'h3 ? 2'h0 : req_size_i);
            beats_left    <= next_beats;
            wshift        <= next_wshift;
            last_internal <= req_internal;
        end
        else if (state == ST_T3)
        begin
            // Longword on a wide area steps a word, narrow areas a byte
            cur_addr   <= cur_addr + (cur_wide ? `BEAT_STEP_16BIT : `BEAT_STEP_8BIT);
            beats_left <= beats_left - 3'h1;
            wshift     <= word_beat ? {wshift[15:0], 16'h0000} : {wshift[23:0], 8'h00};
        end
    end

    // Ready only while idle; a transfer holds off the next request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            req_ready_o <= 1'b0;
        else if (state == ST_IDLE && req_valid_i && req_ready_o && !req_internal)
            req_ready_o <= 1'b0;
        else if (state == ST_T3 && beats_left == 3'h1)
            req_ready_o <= 1'b1;
        else if (state == ST_IDLE)
            req_ready_o <= 1'b1;
    end

    // ------------------------------------------------------------------------
    // Address pins
    // ------------------------------------------------------------------------

    // Mode 1 follows every cycle; mode 2 only external and self-refresh
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_o <= 24'h000000;
        end
        else if (state == ST_IDLE && req_valid_i && req_ready_o)
        begin
            if (update_select || !req_internal)
                addr_o <= req_addr_i;
        end
        else if (state == ST_IDLE && refresh_i)
        begin
            // Mode 2 refresh holds the old address unless self-refresh
            if (update_select || refresh_self_i)
                addr_o <= mode_16m_i ? `AREA2_START_16M : `AREA2_START_1M;
        end
        else if (state == ST_T3 && beats_left != 3'h1)
        begin
            // Next beat of a split transfer; no hold across the split
            addr_o <= cur_addr + (cur_wide ? `BEAT_STEP_16BIT : `BEAT_STEP_8BIT);
        end
    end

    // ------------------------------------------------------------------------
    // Area select pins
    // ------------------------------------------------------------------------

    // In expanded mode, low for the addressed area through the whole external transfer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cs_n_o <= 8'hff;
        end
        else if (state == ST_IDLE && req_valid_i && req_ready_o && expanded_i && !req_internal)
        begin
            cs_n_o <= ~(8'h01 << req_area);
        end
        else if ((state == ST_IDLE) || (state == ST_T3 && beats_left == 3'h1))
        begin
            cs_n_o <= 8'hff;
        end
    end

    // Pin drive enables; never driven outside expanded mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cs_oe_n_o <= 8'hff;
        else
            cs_oe_n_o <= ~(select_enable & {8{expanded_i}});
    end

    // ------------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------------

    // Read strobe covers both lanes; asserted in T2 and T3
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_n_o <= 1'b1;
        else if (state == ST_T1)
            rd_n_o <= cur_we;
        else if (state == ST_T3 || state == ST_IDLE)
            rd_n_o <= 1'b1;
    end

    // Write strobes per lane: narrow upper only, wide byte by address parity
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            upper_write_strobe_n_o <= 1'b1;
            lower_write_strobe_n_o <= 1'b1;
        end
        else if (state == ST_T1 && cur_we)
        begin
            upper_write_strobe_n_o <= cur_wide && !word_beat && cur_addr[0];
            lower_write_strobe_n_o <= !(cur_wide && (word_beat || cur_addr[0]));
        end
        else if (state == ST_T3 || state == ST_IDLE)
        begin
            upper_write_strobe_n_o <= 1'b1;
            lower_write_strobe_n_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Data lanes
    // ------------------------------------------------------------------------

    // Write data; a single byte is copied to the unused lane as filler
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_hi_o      <= 8'h00;
            data_lo_o      <= 8'h00;
            data_hi_oe_n_o <= 1'b1;
            data_lo_oe_n_o <= 1'b1;
        end
        else if (state == ST_T1 && cur_we)
        begin
            data_hi_o      <= wshift[31:24];
            data_lo_o      <= word_beat ? wshift[23:16] : wshift[31:24];
            data_hi_oe_n_o <= 1'b0;
            data_lo_oe_n_o <= !cur_wide;
        end
        else if (state == ST_T3 || state == ST_IDLE)
        begin
            // Reads never drive: invalid lanes stay inputs
            data_hi_oe_n_o <= 1'b1;
            data_lo_oe_n_o <= 1'b1;
        end
    end

    // Read data collected at the end of T3, lane picked per beat
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rshift <= 32'h00000000;
        else if (state == ST_IDLE)
            rshift <= 32'h00000000;
        else if (state == ST_T3 && !cur_we)
        begin
            if (word_beat)
                rshift <= {rshift[15:0], data_hi_i, data_lo_i};
            else if (cur_wide && cur_addr[0])
                rshift <= {rshift[23:0], data_lo_i};
            else
                rshift <= {rshift[23:0], data_hi_i};
        end
    end

    // ------------------------------------------------------------------------
    // Completion to the internal master
    // ------------------------------------------------------------------------

    // One-cycle done; on-chip accesses finish at once with zero data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_o  <= 1'b0;
            rdata_o <= 32'h00000000;
        end
        else if (state == ST_IDLE && req_valid_i && req_ready_o && req_internal)
        begin
            done_o  <= 1'b1;
            rdata_o <= 32'h00000000;
        end
        else if (state == ST_T3 && beats_left == 3'h1)
        begin
            done_o <= 1'b1;
            if (cur_we)
                rdata_o <= 32'h00000000;
            else if (word_beat)
                rdata_o <= {rshift[15:0], data_hi_i, data_lo_i};
            else if (cur_wide && cur_addr[0])
                rdata_o <= {rshift[23:0], data_lo_i};
            else
                rdata_o <= {rshift[23:0], data_hi_i};
        end
        else
        begin
            done_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- verification/ext_bus_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port protocol checks
// ----------------------------------------
module ext_bus_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       done_o,
    input wire logic [7:0] cs_n_o,
    input wire logic       rd_n_o,
    input wire logic       upper_write_strobe_n_o,
    input wire logic       lower_write_strobe_n_o,
    input wire logic       data_hi_oe_n_o,
    input wire logic       data_lo_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers and completion flags are single pulses
    ack_one_cycle_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    ack_follows_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    done_pulse_a: assert property (done_o |=> !done_o) else $error("done held too long");
    // At most one area selected at a time
    one_select_a: assert property ($countones(~cs_n_o) <= 1) else $error("two selects low");
    // Read and upper write strobes only toward a selected area, never both kinds at once
    rd_selects_a: assert property (!rd_n_o |-> cs_n_o != 8'hff) else $error("read without select");
    rd_no_write_a: assert property (!rd_n_o |-> upper_write_strobe_n_o && lower_write_strobe_n_o)
        else $error("read and write together");
    rd_lanes_in_a: assert property (!rd_n_o |-> data_hi_oe_n_o && data_lo_oe_n_o)
        else $error("lane driven in read");
    wr_lane_out_a: assert property (!upper_write_strobe_n_o |-> !data_hi_oe_n_o && (cs_n_o != 8'hff))
        else $error("upper lane not driven");
endmodule
bind external_bus_select_align ext_bus_sva i_sva (.*);
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Parallel static memory on both lanes
// ----------------------------------------
module ext_mem_model (
    input wire logic        clk_i,
    input wire logic [23:0] addr_i,
    input wire logic        cs_n_i,
    input wire logic        rd_n_i,
    input wire logic        upper_write_strobe_n_i,
    input wire logic        lower_write_strobe_n_i,
    input wire logic [7:0]  hi_i,
    input wire logic [7:0]  lo_i,
    output logic      [7:0] hi_o = 8'h5a,
    output logic      [7:0] lo_o = 8'ha5
);
    logic [7:0] mem [256];
    // Each lane stored only under its own strobe, the other lane is junk
    always @(posedge clk_i)
    begin
        if (!cs_n_i && !upper_write_strobe_n_i) mem[addr_i[7:0]] <= hi_i;
        if (!cs_n_i && !lower_write_strobe_n_i) mem[addr_i[7:0] | 8'h01] <= lo_i;
    end
    // Released lanes toggle so stale data can never pass for a read
    always @(posedge clk_i)
    begin
        hi_o <= (!cs_n_i && !rd_n_i) ? mem[addr_i[7:0]] : ~hi_o;
        lo_o <= (!cs_n_i && !rd_n_i) ? mem[addr_i[7:0] | 8'h01] : ~lo_o;
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ext_bus_pkg::*;
    logic clk_i = 0, rst_i = 1, expanded_i = 1, mode_16m_i = 1, rom_enable_i = 0, ram_enable_i = 1;
    logic [7:0] area_width_config_i = 0, data_hi_o, data_lo_o, data_hi_i, data_lo_i, cs_n_o, cs_oe_n_o;
    logic [25:0] adr_i = 0;
    logic [31:0] dat_i = 0, dat_o, req_wdata_i = 0, rdata_o, q, w;
    logic [3:0] sel_i = 4'hf;
    logic we_i = 0, cyc_i = 0, stb_i = 0, ack_o, req_valid_i = 0, req_we_i = 0, req_ready_o, done_o;
    logic [23:0] req_addr_i = 0, addr_o;
    logic [1:0] req_size_i = 0;
    logic refresh_i = 0, refresh_self_i = 0, rd_n_o, upper_write_strobe_n_o, lower_write_strobe_n_o;
    logic data_hi_oe_n_o, data_lo_oe_n_o;
    int mismatches = 0, checked = 0, k;
    always #20 clk_i = ~clk_i;
    external_bus_select_align i_dut (.*);
    ext_mem_model i_mem (.clk_i(clk_i), .addr_i(addr_o), .cs_n_i(cs_n_o[1]), .rd_n_i(rd_n_o),
        .upper_write_strobe_n_i(upper_write_strobe_n_o), .lower_write_strobe_n_i(lower_write_strobe_n_o),
        .hi_i(data_hi_o), .lo_i(data_lo_o), .hi_o(data_hi_i), .lo_o(data_lo_i));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic [23:0] idx, input logic we, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge clk_i);
        {adr_i, we_i, dat_i, cyc_i, stb_i} <= {idx, 2'b00, we, d, 2'b11};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        if (ack_o !== 1'b1)
        begin
            mismatches++;
            end_sim();
        end
        r = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic rq(input logic [23:0] a, input logic we, input logic [1:0] sz, input logic [31:0] d);
        int n = 0;
        {req_addr_i, req_we_i, req_size_i, req_wdata_i, req_valid_i} <= {a, we, sz, d, 1'b1};
        do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 50);
        req_valid_i <= 1'b0;
        do @(posedge clk_i); while (done_o !== 1'b1 && ++n < 100);
        if (done_o !== 1'b1)
        begin
            mismatches++;
            end_sim();
        end
        q = rdata_o;
    endtask
    // Big-endian byte k of a longword
    function automatic logic [7:0] byte_of(input logic [31:0] v, input int i);
        return v[31 - 8 * i -: 8];
    endfunction
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #1ms;
        mismatches++;
        end_sim();
    end
    initial
    begin
        k = $urandom(56);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("select drive", cs_oe_n_o, 8'hfe);
        wb(24'hfee01e, 0, 0, q); check("update ctrl", q, 32'hff);
        wb(24'hfee02f, 1, 32'h5, q); wb(24'hfee02f, 0, 0, q); check("unmapped", q, 0);
        wb(24'hfee020, 1, 32'hf, q); wb(24'hfee01f, 1, 32'hf, q);
        repeat (2) @(posedge clk_i);
        check("select drive", cs_oe_n_o, 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            area_width_config_i <= 8'($urandom); refresh_self_i <= 1'($urandom);
            w = $urandom; k = $urandom % 4;
            rq(24'h200000 | ($urandom % 60) * 4, 1, SIZE_LONG, w);
            rq(req_addr_i, 0, SIZE_LONG, 0); check("long read", q, w);
            rq(req_addr_i + k, 0, SIZE_BYTE, 0); check("byte read", q, byte_of(w, k));
            rq(req_addr_i, 1, SIZE_BYTE, {24'h000000, ~byte_of(w, k)}); w[31 - 8 * k -: 8] = ~byte_of(w, k);
            rq(req_addr_i - k, 0, SIZE_WORD, 0); check("word read", q, {16'h0, w[31:16]});
        end
        rq(24'h200005, 0, SIZE_BYTE, 0); rq(24'hfff000, 0, SIZE_WORD, 0);
        check("address mode1", addr_o, 24'hfff000);
        wb(24'hfee01e, 1, 0, q); wb(24'hfee01e, 0, 0, q); check("update ctrl", q, 32'hfe);
        rq(24'h200005, 0, SIZE_BYTE, 0); rq(24'hfff000, 0, SIZE_WORD, 0);
        check("address mode2", addr_o, 24'h200005);
        check("internal select", cs_n_o, 8'hff);
        {refresh_i, refresh_self_i} <= 2'b10;
        @(posedge clk_i) refresh_i <= 1'b0;
        @(posedge clk_i) check("refresh hold", addr_o, 24'h200005);
        {refresh_i, refresh_self_i} <= 2'b11;
        @(posedge clk_i) refresh_i <= 1'b0;
        @(posedge clk_i) check("self refresh", addr_o, 24'h400000);
        // Second reset with the ROM strap set: all low selects stay inputs
        {rst_i, rom_enable_i} <= 2'b11;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("select drive", cs_oe_n_o, 8'hff);
        wb(24'hfee01e, 0, 0, q); check("update ctrl", q, 32'hff);
        end_sim();
    end
endmodule
`default_nettype wire
